// ==== core/fmpc_pkg.sv ====
// fmpc_pkg: constants, register map and types of the filtered pulse counter
// assumes a single 250 MHz clock domain shared by every design file
package fmpc_pkg;
  // ==========================================================
  // clock and time base
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          CLK_HZ        = 250000000;
  localparam int          US_IN_NS      = 1000;
  localparam int          CYC_PER_US    = US_IN_NS / CLK_PERIOD_NS;
  localparam logic [14:0] FILT_W_MIN    = 15'h0001;  // 1 us
  localparam logic [14:0] FILT_W_MAX    = 15'h7FFF;  // 32767 us
  localparam int          HS_PULSES     = 11;
  localparam int          NORM_PULSES   = 1;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_FILT_EN = 8'h00;
  localparam logic [7:0] OFS_INVERT  = 8'h04;
  localparam logic [7:0] OFS_MODE    = 8'h08;
  localparam logic [7:0] OFS_HSPEED  = 8'h0C;
  localparam logic [7:0] OFS_CLEAR   = 8'h10;
  localparam logic [7:0] OFS_FILT_W0 = 8'h14;
  localparam logic [7:0] OFS_FILT_W1 = 8'h18;
  localparam logic [7:0] OFS_FILT_W2 = 8'h1C;
  localparam logic [7:0] OFS_COUNT0  = 8'h20;  // counts at 0x20 + 4*channel

  // ==========================================================
  // reset values
  localparam logic [2:0]  RST_FILT_EN = 3'h0;        // all filters off
  localparam logic [7:0]  RST_INVERT  = 8'h00;       // isolated inputs
  localparam logic [23:0] RST_MODE    = 24'h6DB6DB;  // mode 3 in every channel
  localparam logic [7:0]  RST_HSPEED  = 8'h00;
  localparam logic [14:0] RST_FILT_W  = 15'h0001;

  // ==========================================================
  // counting modes (3-bit field per channel)
  typedef enum logic [2:0] {
    FMPC_MODE_DIRPULSE = 3'h0,
    FMPC_MODE_UPDOWN   = 3'h1,
    FMPC_MODE_FREQ     = 3'h2,
    FMPC_MODE_UP       = 3'h3,
    FMPC_MODE_QUAD     = 3'h4
  } fmpc_mode_type;

  // active-low counting: a falling edge is an event
  function automatic logic fmpc_fall(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction
endpackage

// ==== core/fmpc_filt.sv ====
// fmpc_filt: one second-order low-pass noise filter for a group of inputs
// assumes synchronised inputs on hclk; bypassed when disabled
`timescale 1ns/100ps
module fmpc_filt #(
  parameter int N = 2
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              enable,
  input  wire logic [14:0]       width_us,
  input  wire logic [N-1:0]      din,
  output      logic [N-1:0]      dout
);
  import fmpc_pkg::*;

  logic [7:0]   us_cnt_ff;
  logic [14:0]  t_cnt_ff;
  logic         tick;
  logic [N-1:0] samp_ff;
  logic [N-1:0] filt_ff;
  logic [14:0]  width_eff;

  // a zero width would stall the clock, treat it as the minimum
  assign width_eff = (width_us < FILT_W_MIN) ? FILT_W_MIN : width_us;
  assign tick      = (us_cnt_ff == 8'(CYC_PER_US - 1)) && (t_cnt_ff >= width_eff - 15'h0001);

  // ==========================================================
  // filtering clock: one tick every width_us microseconds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      us_cnt_ff <= 8'h00;
      t_cnt_ff  <= 15'h0000;
    end else if (us_cnt_ff == 8'(CYC_PER_US - 1)) begin
      us_cnt_ff <= 8'h00;
      t_cnt_ff  <= tick ? 15'h0000 : t_cnt_ff + 15'h0001;
    end else begin
      us_cnt_ff <= us_cnt_ff + 8'h01;
    end
  end

  // ==========================================================
  // output moves only after two equal samples on successive ticks;
  // a high shorter than T is seen at most once, longer than 2T at least twice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_ff <= '1;
      filt_ff <= '1;
    end else if (tick) begin
      samp_ff <= din;
      filt_ff <= (din & ~(samp_ff ^ din)) | (filt_ff & (samp_ff ^ din));
    end
  end

  // disabled filter passes inputs straight through
  assign dout = enable ? filt_ff : din;
endmodule // fmpc_filt

// ==== core/fmpc_chan.sv ====
// fmpc_chan: counter and frequency meter of one channel
// assumes filtered, inverted inputs on hclk; side_a marks the even channel
`timescale 1ns/100ps
module fmpc_chan #(
  parameter bit SIDE_A = 1'b1
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic [2:0]    mode,
  input  wire logic          hspeed,
  input  wire logic          clear,
  input  wire logic          sig_self,
  input  wire logic          sig_other,
  output      logic [31:0]   value
);
  import fmpc_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DIV  = 2'b10
  } fmpc_div_state_type;

  logic               self_d_ff;
  logic               other_d_ff;
  logic               fall_self;
  logic               fall_other;
  logic [31:0]        count_ff;
  logic [31:0]        per_ff;
  logic [31:0]        sum_ff;
  logic [3:0]         npulse_ff;
  logic               seen_ff;
  logic [31:0]        quo_ff;
  logic [32:0]        rem_ff;
  logic [31:0]        dvd_ff;
  logic [31:0]        dvs_ff;
  logic [5:0]         bit_ff;
  logic [31:0]        freq_ff;
  logic [32:0]        rem_try;
  logic [3:0]         need;
  fmpc_div_state_type st_ff;

  assign fall_self  = fmpc_fall(self_d_ff, sig_self);
  assign fall_other = fmpc_fall(other_d_ff, sig_other);
  assign need       = hspeed ? 4'(HS_PULSES) : 4'(NORM_PULSES);
  assign rem_try    = {rem_ff[31:0], dvd_ff[31]};
  assign value      = (mode == FMPC_MODE_FREQ) ? freq_ff : count_ff;

  // edge history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      self_d_ff  <= 1'b1;
      other_d_ff <= 1'b1;
    end else begin
      self_d_ff  <= sig_self;
      other_d_ff <= sig_other;
    end
  end

  // ==========================================================
  // event counter; pair modes count on the A channel only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff <= 32'h00000000;
    end else if (clear) begin
      count_ff <= 32'h00000000;
    end else begin
      case (mode)
        FMPC_MODE_DIRPULSE: begin
          if (SIDE_A && fall_self)
            count_ff <= sig_other ? count_ff - 32'h1 : count_ff + 32'h1;
        end
        FMPC_MODE_UPDOWN: begin
          if (SIDE_A && (fall_self != fall_other))
            count_ff <= fall_self ? count_ff + 32'h1 : count_ff - 32'h1;
        end
        FMPC_MODE_UP: begin
          if (fall_self)
            count_ff <= count_ff + 32'h1;
        end
        FMPC_MODE_QUAD: begin
          // x1 decode: B still high at A fall means A leads
          if (SIDE_A && fall_self)
            count_ff <= sig_other ? count_ff + 32'h1 : count_ff - 32'h1;
        end
        default: count_ff <= count_ff;
      endcase
    end
  end

  // ==========================================================
  // period gathering: one or eleven periods between falling edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_ff    <= 32'h00000000;
      sum_ff    <= 32'h00000000;
      npulse_ff <= 4'h0;
      seen_ff   <= 1'b0;
    end else if (mode != FMPC_MODE_FREQ || clear) begin
      per_ff    <= 32'h00000000;
      sum_ff    <= 32'h00000000;
      npulse_ff <= 4'h0;
      seen_ff   <= 1'b0;
    end else if (fall_self) begin
      per_ff  <= 32'h00000001;
      seen_ff <= 1'b1;
      if (seen_ff) begin
        if (npulse_ff + 4'h1 >= need) begin
          sum_ff    <= 32'h00000000;
          npulse_ff <= 4'h0;
        end else begin
          sum_ff    <= sum_ff + per_ff;
          npulse_ff <= npulse_ff + 4'h1;
        end
      end
    end else if (per_ff != 32'hFFFFFFFF) begin
      per_ff <= per_ff + 32'h1;                   // saturate on a stopped input
    end
  end

  // ==========================================================
  // frequency = pulses * clk / cycles, serial restoring divide
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff   <= ST_IDLE;
      quo_ff  <= 32'h00000000;
      rem_ff  <= 33'h000000000;
      dvd_ff  <= 32'h00000000;
      dvs_ff  <= 32'h00000001;
      bit_ff  <= 6'h00;
      freq_ff <= 32'h00000000;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (mode == FMPC_MODE_FREQ && fall_self && seen_ff && npulse_ff + 4'h1 >= need) begin
            dvd_ff <= 32'(CLK_HZ) * 32'(need);
            dvs_ff <= sum_ff + per_ff;
            rem_ff <= 33'h000000000;
            quo_ff <= 32'h00000000;
            bit_ff <= 6'h00;
            st_ff  <= ST_DIV;
          end
        end
        ST_DIV: begin
          dvd_ff <= {dvd_ff[30:0], 1'b0};
          if (rem_try >= {1'b0, dvs_ff}) begin
            rem_ff <= rem_try - {1'b0, dvs_ff};
            quo_ff <= {quo_ff[30:0], 1'b1};
          end else begin
            rem_ff <= rem_try;
            quo_ff <= {quo_ff[30:0], 1'b0};
          end
          bit_ff <= bit_ff + 6'h01;
          if (bit_ff == 6'h1F) begin
            freq_ff <= (rem_try >= {1'b0, dvs_ff}) ? {quo_ff[30:0], 1'b1} : {quo_ff[30:0], 1'b0};
            st_ff   <= ST_IDLE;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end
endmodule // fmpc_chan

// ==== core/fmpc_top.sv ====
// fmpc_top: eight-input filtered multimode pulse counter with AHB-Lite registers
// assumes a single AHB-Lite master and asynchronous pulse inputs on pins
//
// Behaviour
// - three independent second-order noise filters
// - filter width programmable 1 to 32767 us
// - per-filter enable; disabled passes input through
// - filtering applies in every counting mode
// - all filters disabled after reset
// - high pulse shorter than T is rejected
// - high pulse longer than 2T is passed
// - dir/pulse: A fall counts, B sets direction
// - up/down: A fall up, B fall down
// - frequency mode derives frequency from counted time
// - normal sub-mode measures a single pulse
// - high-speed sub-mode averages eleven pulses
// - up mode: every A fall increments
// - quadrature: A leading B increments
// - quadrature: A lagging B decrements
// - optional per-input inversion before counting
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
module fmpc_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic        hresp,
  output      logic [31:0] hrdata,
  input  wire logic [3:0]  channel_a_input,
  input  wire logic [3:0]  channel_b_input
);
  import fmpc_pkg::*;

  logic [2:0]   filt_en_ff;
  logic [7:0]   invert_ff;
  logic [23:0]  mode_ff;
  logic [7:0]   hspeed_ff;
  logic [14:0]  filt_w_ff [3];
  logic [7:0]   clear_ff;
  logic         wr_ff;
  logic [7:0]   wr_addr_ff;
  logic         hreadyout_ff;
  logic         hresp_ff;
  logic [31:0]  hrdata_ff;
  logic [7:0]   raw;
  logic [7:0]   sync1_ff;
  logic [7:0]   sync2_ff;
  logic [7:0]   sync3_ff;
  logic [7:0]   stable_ff;
  logic [7:0]   inv;
  logic [7:0]   filt;
  logic [31:0]  value [8];
  logic         addr_phase;
  logic [31:0]  nxt_rdata;

  assign hreadyout = hreadyout_ff;
  assign hresp     = hresp_ff;
  assign hrdata    = hrdata_ff;

  // ==========================================================
  // pin conditioning: channel 2p is A of pair p, 2p+1 is B
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      raw[2*p]   = channel_a_input[p];
      raw[2*p+1] = channel_b_input[p];
    end
  end

  // three-stage synchroniser; a change counts once stages 2 and 3 agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff  <= 8'hFF;
      sync2_ff  <= 8'hFF;
      sync3_ff  <= 8'hFF;
      stable_ff <= 8'hFF;
    end else begin
      sync1_ff  <= raw;
      sync2_ff  <= sync1_ff;
      sync3_ff  <= sync2_ff;
      stable_ff <= (sync2_ff & sync3_ff) | (stable_ff & (sync2_ff | sync3_ff));
    end
  end

  // direct logic-level inputs are inverted so counting stays on falls
  assign inv = stable_ff ^ invert_ff;

  // ==========================================================
  // noise filters, ahead of every counting and frequency mode
  fmpc_filt #(.N(2)) u_filt0 (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .enable   (filt_en_ff[0]),
    .width_us (filt_w_ff[0]),
    .din      (inv[1:0]),
    .dout     (filt[1:0])
  );

  fmpc_filt #(.N(2)) u_filt1 (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .enable   (filt_en_ff[1]),
    .width_us (filt_w_ff[1]),
    .din      (inv[3:2]),
    .dout     (filt[3:2])
  );

  fmpc_filt #(.N(4)) u_filt2 (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .enable   (filt_en_ff[2]),
    .width_us (filt_w_ff[2]),
    .din      (inv[7:4]),
    .dout     (filt[7:4])
  );

  // ==========================================================
  // channels; pair modes need only the A channel's mode field, as A reads B through sig_other
  for (genvar c = 0; c < 8; c++) begin : g_chan
    fmpc_chan #(.SIDE_A((c % 2) == 0)) u_chan (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .mode      (mode_ff[3*c +: 3]),
      .hspeed    (hspeed_ff[c]),
      .clear     (clear_ff[c]),
      .sig_self  (filt[c]),
      .sig_other (filt[c ^ 1]),
      .value     (value[c])
    );
  end

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  assign addr_phase = hsel && htrans[1] && hready;

  // read mux, sampled in the address phase so data stand in the data phase
  always_comb begin
    nxt_rdata = 32'h00000000;
    case (haddr[7:0])
      OFS_FILT_EN: nxt_rdata = {29'h0, filt_en_ff};
      OFS_INVERT:  nxt_rdata = {24'h0, invert_ff};
      OFS_MODE:    nxt_rdata = {8'h0, mode_ff};
      OFS_HSPEED:  nxt_rdata = {24'h0, hspeed_ff};
      OFS_FILT_W0: nxt_rdata = {17'h0, filt_w_ff[0]};
      OFS_FILT_W1: nxt_rdata = {17'h0, filt_w_ff[1]};
      OFS_FILT_W2: nxt_rdata = {17'h0, filt_w_ff[2]};
      default: begin
        if (haddr[7:5] == OFS_COUNT0[7:5])
          nxt_rdata = value[haddr[4:2]];
      end
    endcase
    if (haddr[31:8] != 24'h000000)
      nxt_rdata = 32'h00000000;                 // unmapped reads as zero
  end

  // bus handshake and captured address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      hrdata_ff    <= 32'h00000000;
      wr_ff        <= 1'b0;
      wr_addr_ff   <= 8'h00;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      wr_ff        <= addr_phase && hwrite && (haddr[31:8] == 24'h000000);
      wr_addr_ff   <= haddr[7:0];
      if (addr_phase && !hwrite)
        hrdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // configuration registers, written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_en_ff   <= RST_FILT_EN;
      invert_ff    <= RST_INVERT;
      mode_ff      <= RST_MODE;
      hspeed_ff    <= RST_HSPEED;
      filt_w_ff[0] <= RST_FILT_W;
      filt_w_ff[1] <= RST_FILT_W;
      filt_w_ff[2] <= RST_FILT_W;
    end else if (wr_ff) begin
      case (wr_addr_ff)
        OFS_FILT_EN: filt_en_ff   <= hwdata[2:0];
        OFS_INVERT:  invert_ff    <= hwdata[7:0];
        OFS_MODE:    mode_ff      <= hwdata[23:0];
        OFS_HSPEED:  hspeed_ff    <= hwdata[7:0];
        OFS_FILT_W0: filt_w_ff[0] <= hwdata[14:0];
        OFS_FILT_W1: filt_w_ff[1] <= hwdata[14:0];
        OFS_FILT_W2: filt_w_ff[2] <= hwdata[14:0];
        default:     filt_en_ff   <= filt_en_ff;
      endcase
    end
  end

  // write-one-to-clear pulse for counters, one cycle long
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      clear_ff <= 8'h00;
    else
      clear_ff <= (wr_ff && wr_addr_ff == OFS_CLEAR) ? hwdata[7:0] : 8'h00;
  end
endmodule // fmpc_top

// ==== tb/fmpc_top_properties.sv ====
// fmpc_top_properties: bus-side assertions of the filtered pulse counter
// assumes it is bound to fmpc_top and sees only that module's ports
`timescale 1ns/100ps
module fmpc_top_checker
  import fmpc_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [3:0]  channel_a_input,
  input wire logic [3:0]  channel_b_input
);
  // ==========================================================
  // decode of accepted transfers
  logic rd_take;
  logic wr_take;
  logic low_page;
  logic fen_wr_ff;
  assign low_page = (haddr[31:8] == 24'h000000);
  assign rd_take  = hsel & htrans[1] & hready & ~hwrite;
  assign wr_take  = hsel & htrans[1] & hready & hwrite;
  // reset-value check of the enable word stops once software writes it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fen_wr_ff <= 1'b0;
    end else if (wr_take && low_page && haddr[7:0] == OFS_FILT_EN) begin
      fen_wr_ff <= 1'b1;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a read of word ofs returns zero in the bits set in mask
  property p_read_mask(logic [7:0] ofs, logic [31:0] mask);
    rd_take && low_page && haddr[7:0] == ofs |=> (hrdata & mask) == 32'h00000000;
  endproperty
  a_ready_high: assert property (hreadyout [*2])
    else $error("hreadyout dropped");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_rdata_holds: assert property (!rd_take |=> $stable(hrdata))
    else $error("hrdata changed without a read");
  a_unmapped_zero: assert property (rd_take && !low_page |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_enable_narrow: assert property (p_read_mask(OFS_FILT_EN, 32'hFFFFFFF8))
    else $error("filter enable word too wide");
  a_enable_reset: assert property (p_read_mask(OFS_FILT_EN, {32{~fen_wr_ff}}))
    else $error("filters not off after reset");
  a_width_narrow: assert property (p_read_mask(OFS_FILT_W2, 32'hFFFF8000))
    else $error("filter width word too wide");
  a_invert_narrow: assert property (p_read_mask(OFS_INVERT, 32'hFFFFFF00))
    else $error("invert word too wide");
  a_clear_zero: assert property (p_read_mask(OFS_CLEAR, 32'hFFFFFFFF))
    else $error("clear word reads nonzero");
  c_read: cover property (rd_take ##1 rd_take);
  c_write: cover property (wr_take && haddr[7:0] == OFS_FILT_EN);
  c_unmapped: cover property (rd_take && !low_page);
endmodule // fmpc_top_checker

bind fmpc_top fmpc_top_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .channel_a_input(channel_a_input), .channel_b_input(channel_b_input));

// ==== tb/fmpc_src_model.sv ====
// fmpc_src_model: pulse, direction and encoder sources on the eight input pins
// assumes the bench calls its tasks just after a rising edge of hclk
`timescale 1ns/100ps
module fmpc_src_model (
  input  wire logic       hclk,
  output      logic [3:0] chan_a,
  output      logic [3:0] chan_b
);
  // ==========================================================
  // pin drivers
  // isolated sources rest high, so a count is a high-to-low step
  initial begin
    chan_a = 4'hF;
    chan_b = 4'hF;
  end
  // drives pin idx (channel number: even is A, odd is B) at the next edge
  task automatic set_pin(input int idx, input logic v);
    @(posedge hclk);
    if (idx[0]) chan_b[idx >> 1] <= v;
    else chan_a[idx >> 1] <= v;
  endtask
  // low for lo cycles, then high for hi cycles; fast and slow sources differ only here
  task automatic pulse(input int idx, input int lo, input int hi);
    set_pin(idx, 1'b0);
    repeat (lo - 1) @(posedge hclk);
    set_pin(idx, 1'b1);
    repeat (hi - 1) @(posedge hclk);
  endtask
endmodule // fmpc_src_model

// ==== tb/tb_filtered_multimode_pulse_counter.sv ====
// tb_filtered_multimode_pulse_counter: self-checking bench of fmpc_top
// assumes the source model on the pins and one AHB-Lite master task set
`timescale 1ns/100ps
module tb_filtered_multimode_pulse_counter;
  import fmpc_pkg::*;
  `define CHECK_EQ(got, exp) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [3:0]  chan_a;
  logic [3:0]  chan_b;
  int          bad_count  = 0;
  int          n_compared = 0;
  localparam logic [31:0] MODE_RST = {8'h00, RST_MODE};

  // ==========================================================
  // clock, parts and watchdog
  always #2 hclk = ~hclk;
  fmpc_src_model src (.hclk(hclk), .chan_a(chan_a), .chan_b(chan_b));
  fmpc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .channel_a_input(chan_a),
    .channel_b_input(chan_b));
  // the tests take about 11500 cycles; five times that means a hang
  initial begin
    repeat (60000) @(posedge hclk);
    bad_count++;
    give_verdict();
  end

  // ==========================================================
  // bus and helper tasks
  task automatic give_verdict();
    $display("compared %0d, wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [31:0] ra(input logic [7:0] o);
    return {24'h000000, o};
  endfunction
  function automatic logic [31:0] ca(input int c);
    return ra(OFS_COUNT0) + 32'(4 * c);
  endfunction
  // address phase held until hready, then data phase held until hready
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    // only the watchdog ends a wait for hready
    do begin @(posedge hclk); end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); end while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    `CHECK_EQ(r, e)
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic step(input int idx, input logic v);
    src.set_pin(idx, v);
    idle(10);
  endtask
  task automatic both(input logic v, input int n);
    fork
      src.set_pin(0, v);
      src.set_pin(2, v);
    join
    idle(n - 1);
  endtask

  // ==========================================================
  // scenarios
  task automatic chk_reset();
    rd_chk(ra(OFS_FILT_EN), 32'h00000000);
    rd_chk(ra(OFS_MODE), MODE_RST);
    rd_chk(ra(OFS_FILT_W1), {17'h00000, RST_FILT_W});
    rd_chk(ra(OFS_FILT_W2), {17'h00000, RST_FILT_W});
    wr(ra(OFS_FILT_W2), {17'h00000, FILT_W_MAX});
    rd_chk(ra(OFS_FILT_W2), {17'h00000, FILT_W_MAX});
    rd_chk(32'h00000100, 32'h00000000);
    rd_chk(ca(7), 32'h00000000);
  endtask
  task automatic chk_freq();
    wr(ra(OFS_HSPEED), 32'h00000002); // channel 1 sees the fast train
    wr(ra(OFS_MODE), (MODE_RST & 32'hFFFFFFC0) | 32'h00000012);
    fork
      begin
        repeat (2) src.pulse(0, 500, 500);
        src.set_pin(0, 1'b0);
      end
      begin
        repeat (10) src.pulse(1, 250, 250);
        src.pulse(1, 300, 300);
        src.set_pin(1, 1'b0);
      end
    join
    idle(60);
    rd_chk(ca(0), 32'(CLK_HZ / 1000));
    rd_chk(ca(1), 32'((64'(CLK_HZ) * 11) / 5600));
    src.set_pin(0, 1'b1);
    src.set_pin(1, 1'b1);
  endtask
  task automatic chk_up();
    wr(ra(OFS_MODE), MODE_RST);
    wr(ra(OFS_CLEAR), 32'h000000FF);
    repeat (3) src.pulse(0, 20, 20);
    repeat (2) src.pulse(1, 20, 20);
    idle(12);
    rd_chk(ca(0), 32'h00000003);
    rd_chk(ca(1), 32'h00000002);
    rd_chk(ra(OFS_CLEAR), 32'h00000000);
  endtask
  task automatic chk_dirpulse();
    wr(ra(OFS_MODE), MODE_RST & 32'hFFFFFFC0); // both halves of the pair
    wr(ra(OFS_CLEAR), 32'h00000003);
    step(1, 1'b0);
    repeat (3) src.pulse(0, 20, 20);
    step(1, 1'b1);
    src.pulse(0, 20, 20);
    idle(12);
    rd_chk(ca(0), 32'h00000002);
    rd_chk(ca(1), 32'h00000000);
  endtask
  task automatic chk_updown();
    wr(ra(OFS_MODE), (MODE_RST & 32'hFFFFFFC0) | 32'h00000009);
    wr(ra(OFS_CLEAR), 32'h00000003);
    repeat (3) src.pulse(0, 20, 20);
    src.pulse(1, 20, 20);
    fork
      src.pulse(0, 20, 20);
      src.pulse(1, 20, 20);
    join
    idle(12);
    rd_chk(ca(0), 32'h00000002);
  endtask
  task automatic chk_quad();
    wr(ra(OFS_MODE), (MODE_RST & 32'hFFFFFFC0) | 32'h00000024);
    wr(ra(OFS_CLEAR), 32'h00000003);
    repeat (2) begin
      step(0, 1'b0);
      step(1, 1'b0);
      step(0, 1'b1);
      step(1, 1'b1);
    end
    rd_chk(ca(0), 32'h00000002);
    step(1, 1'b0);
    step(0, 1'b0);
    step(1, 1'b1);
    step(0, 1'b1);
    rd_chk(ca(0), 32'h00000001);
  endtask
  task automatic chk_invert();
    wr(ra(OFS_MODE), MODE_RST);
    step(2, 1'b0);
    wr(ra(OFS_INVERT), 32'h00000004); // direct input on channel 2
    idle(10);
    wr(ra(OFS_CLEAR), 32'h00000004);
    repeat (2) begin
      step(2, 1'b1);
      step(2, 1'b0);
    end
    rd_chk(ca(2), 32'h00000002);
    rd_chk(ra(OFS_INVERT), 32'h00000004);
    step(2, 1'b1);
    wr(ra(OFS_INVERT), 32'h00000000);
  endtask
  task automatic chk_filter();
    wr(ra(OFS_CLEAR), 32'h00000005);
    wr(ra(OFS_FILT_EN), 32'h00000001); // filter 0 only
    idle(20);
    both(1'b0, 1000);
    both(1'b1, 100);
    both(1'b0, 1000);
    both(1'b1, 800);
    both(1'b0, 1000);
    both(1'b1, 1000);
    rd_chk(ca(0), 32'h00000002);
    rd_chk(ca(0), 32'h00000002);
    rd_chk(ca(2), 32'h00000003);
    rd_chk(ra(OFS_FILT_EN), 32'h00000001);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h00000000;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h00000000;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_reset();
    chk_freq();
    chk_up();
    chk_dirpulse();
    chk_updown();
    chk_quad();
    chk_invert();
    chk_filter();
    give_verdict();
  end
endmodule // tb_filtered_multimode_pulse_counter
